//--- rtl/tefl_map.svh
// Purpose: Register offsets, bit positions, reset values and mode codes of the timer event flag block
// Assumes: APB byte addresses, one 32-bit aligned word per register
// Notes: Definitions only
`ifndef TEFL_MAP_SVH
`define TEFL_MAP_SVH

// Register byte offsets
`define TEFL_OFS_FLAGS 12'h000
`define TEFL_OFS_MASK 12'h004
`define TEFL_OFS_CTRL 12'h008
`define TEFL_OFS_CAPT 12'h00C

// Flag register bit positions
`define TEFL_BIT_SECOND_MATCH 7
`define TEFL_BIT_SECOND_OVF 6
`define TEFL_BIT_CAPTURE 5
`define TEFL_BIT_CMP_A 4
`define TEFL_BIT_CMP_B 3
`define TEFL_BIT_WIDE_OVF 2
`define TEFL_BIT_FIRST_MATCH 1
`define TEFL_BIT_FIRST_OVF 0

// Control register field positions
`define TEFL_CTRL_MODE_LSB 0
`define TEFL_CTRL_MODE_MSB 3
`define TEFL_CTRL_EDGE_BIT 4
`define TEFL_CTRL_GIE_BIT 5

// Reset values
`define TEFL_FLAGS_RST 8'h00
`define TEFL_MASK_RST 8'h00
`define TEFL_CTRL_RST 6'h00
`define TEFL_CAPT_RST 16'h0000

// Waveform modes of interest
`define TEFL_MODE_NORMAL 4'h0
`define TEFL_MODE_CTC_OCRA 4'h4
`define TEFL_MODE_CTC_CAPT 4'hC
`define TEFL_MODE_FPWM_CAPT 4'hE
`define TEFL_MODE_PFC_CAPT 4'h8
`define TEFL_MODE_PC_CAPT 4'hA

// Counter maximum
`define TEFL_COUNT_MAX 16'hFFFF

`endif

//--- rtl/tefl_pkg.sv
// Purpose: Shared types of the timer event flag block
// Assumes: Constants live in tefl_map.svh
// Notes: Types only
package tefl_pkg;
   typedef logic [3:0] tefl_mode_t;
   typedef logic [7:0] tefl_byte_t;
   typedef logic [15:0] tefl_word_t;
endpackage

//--- rtl/tefl_pin_edge.sv
// Purpose: Synchronise the capture pin and report its rising and falling edges
// Assumes: Pin is asynchronous to pclk
// Notes: Edges are one-cycle pulses, two cycles behind the pin
`timescale 1ns/10ps
module tefl_pin_edge
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pin,
   output logic rise,
   output logic fall
);
   logic meta_reg;
   logic sync_reg;
   logic prev_reg;

   // Two-stage synchroniser, then one stage of history
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         prev_reg <= 1'b0;
      end
      else
      begin
         meta_reg <= pin;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   // Edge decode reads only settled stages
   assign rise = sync_reg & ~prev_reg;
   assign fall = ~sync_reg & prev_reg;
endmodule

//--- rtl/tefl_top.sv
// Purpose: Event flag logic of the 16-bit timer: capture, compare A, compare B and overflow flags
// Assumes: Datapath inputs share pclk; timer_tick is a one-cycle timer clock enable
// Notes: Registers reached over APB; pready comes one cycle after setup
`timescale 1ns/10ps
`include "tefl_map.svh"
module tefl_top
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic timer_tick,
   input wire tefl_pkg::tefl_word_t wide_counter_value,
   input wire tefl_pkg::tefl_word_t compare_register_a,
   input wire tefl_pkg::tefl_word_t compare_register_b,
   input wire logic force_compare_a_strobe,
   input wire logic force_compare_b_strobe,
   input wire logic mode_overflow_event,
   input wire logic capture_input_pin,
   input wire logic [3:0] other_timer_flag_set,
   input wire logic [3:0] vector_executed,
   output logic [3:0] irq_request,
   output logic compare_a_event,
   output logic compare_b_event,
   output tefl_pkg::tefl_word_t capture_register,
   output tefl_pkg::tefl_mode_t waveform_mode_field
);
   import tefl_pkg::*;

   tefl_byte_t timer_interrupt_flags_reg;
   tefl_byte_t timer_interrupt_flags_next;
   tefl_byte_t timer_interrupt_mask_reg;
   tefl_byte_t timer_interrupt_mask_next;
   logic [5:0] ctrl_reg;
   logic [5:0] ctrl_next;
   tefl_word_t capture_reg;
   tefl_word_t capture_next;
   logic hit_a_reg;
   logic hit_a_next;
   logic hit_b_reg;
   logic hit_b_next;
   logic [3:0] irq_reg;
   logic [3:0] irq_next;
   logic cmp_a_out_reg;
   logic cmp_a_out_next;
   logic cmp_b_out_reg;
   logic cmp_b_out_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic pready_reg;
   logic pready_next;
   logic pslverr_reg;
   logic pslverr_next;
   logic pin_rise;
   logic pin_fall;
   logic wr_en;
   logic addr_ok;
   logic capt_is_top;
   logic ovf_plain_mode;
   logic capture_evt;
   tefl_byte_t set_vec;
   tefl_byte_t clr_vec;
   tefl_mode_t mode;
   logic edge_sel;
   logic gie;

   assign mode = ctrl_reg[`TEFL_CTRL_MODE_MSB:`TEFL_CTRL_MODE_LSB];
   assign edge_sel = ctrl_reg[`TEFL_CTRL_EDGE_BIT];
   assign gie = ctrl_reg[`TEFL_CTRL_GIE_BIT];

   // Pin edges after a two-stage synchroniser
   tefl_pin_edge u_pin_edge
   (
      .pclk(pclk),
      .presetn(presetn),
      .pin(capture_input_pin),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   // Mode decode; capture-as-ceiling modes disconnect the pin
   assign capt_is_top = (mode == `TEFL_MODE_CTC_CAPT) || (mode == `TEFL_MODE_FPWM_CAPT) ||
                        (mode == `TEFL_MODE_PFC_CAPT) || (mode == `TEFL_MODE_PC_CAPT);
   assign ovf_plain_mode = (mode == `TEFL_MODE_NORMAL) || (mode == `TEFL_MODE_CTC_OCRA) ||
                           (mode == `TEFL_MODE_CTC_CAPT);

   assign capture_evt = ~capt_is_top & (edge_sel ? pin_rise : pin_fall);

   // APB decode; a write lands only at the edge where pready is sampled high
   assign addr_ok = (paddr == `TEFL_OFS_FLAGS) || (paddr == `TEFL_OFS_MASK) ||
                    (paddr == `TEFL_OFS_CTRL) || (paddr == `TEFL_OFS_CAPT);
   assign wr_en = psel & penable & pready_reg & pwrite & addr_ok;

   // Compare pipelines and overflow; compares and plain-mode overflow paced by the timer clock enable, mode_overflow_event not
   always_comb
   begin
      hit_a_next = hit_a_reg;
      hit_b_next = hit_b_reg;
      set_vec = 8'h00;
      // match seen now, flag next tick
      if (timer_tick)
      begin
         hit_a_next = (wide_counter_value == compare_register_a);
         set_vec[`TEFL_BIT_CMP_A] = hit_a_reg;
      end
      if (timer_tick)
      begin
         hit_b_next = (wide_counter_value == compare_register_b);
         set_vec[`TEFL_BIT_CMP_B] = hit_b_reg;
      end
      if (capt_is_top)
      begin
         set_vec[`TEFL_BIT_CAPTURE] = timer_tick & (wide_counter_value == capture_reg);
      end
      else
      begin
         set_vec[`TEFL_BIT_CAPTURE] = capture_evt;
      end
      if (ovf_plain_mode)
      begin
         set_vec[`TEFL_BIT_WIDE_OVF] = timer_tick & (wide_counter_value == `TEFL_COUNT_MAX);
      end
      else
      begin
         set_vec[`TEFL_BIT_WIDE_OVF] = mode_overflow_event;
      end
      // Other timers only share the register
      set_vec[`TEFL_BIT_SECOND_MATCH] = other_timer_flag_set[3];
      set_vec[`TEFL_BIT_SECOND_OVF] = other_timer_flag_set[2];
      set_vec[`TEFL_BIT_FIRST_MATCH] = other_timer_flag_set[1];
      set_vec[`TEFL_BIT_FIRST_OVF] = other_timer_flag_set[0];
   end

   // Flag clears from vectors and from software
   always_comb
   begin
      clr_vec = 8'h00;
      clr_vec[`TEFL_BIT_CAPTURE] = vector_executed[3];
      clr_vec[`TEFL_BIT_CMP_A] = vector_executed[2];
      clr_vec[`TEFL_BIT_CMP_B] = vector_executed[1];
      clr_vec[`TEFL_BIT_WIDE_OVF] = vector_executed[0];
      if (wr_en && (paddr == `TEFL_OFS_FLAGS))
      begin
         clr_vec = clr_vec | pwdata[7:0];
      end
   end

   // Flag, mask, control and capture next values
   always_comb
   begin
      timer_interrupt_flags_next = (timer_interrupt_flags_reg & ~clr_vec) | set_vec;
      timer_interrupt_mask_next = timer_interrupt_mask_reg;
      ctrl_next = ctrl_reg;
      capture_next = capture_reg;
      if (wr_en && (paddr == `TEFL_OFS_MASK))
      begin
         timer_interrupt_mask_next = pwdata[7:0];
      end
      if (wr_en && (paddr == `TEFL_OFS_CTRL))
      begin
         ctrl_next = pwdata[5:0];
      end
      if (capture_evt)
      begin
         capture_next = wide_counter_value;
      end
   end

   // Interrupt requests and compare outputs to the waveform side
   always_comb
   begin
      irq_next[3] = gie & timer_interrupt_flags_reg[`TEFL_BIT_CAPTURE] & timer_interrupt_mask_reg[`TEFL_BIT_CAPTURE];
      irq_next[2] = gie & timer_interrupt_flags_reg[`TEFL_BIT_CMP_A] & timer_interrupt_mask_reg[`TEFL_BIT_CMP_A];
      irq_next[1] = gie & timer_interrupt_flags_reg[`TEFL_BIT_CMP_B] & timer_interrupt_mask_reg[`TEFL_BIT_CMP_B];
      irq_next[0] = gie & timer_interrupt_flags_reg[`TEFL_BIT_WIDE_OVF] &
                    timer_interrupt_mask_reg[`TEFL_BIT_WIDE_OVF];
      // forced strobe reaches output only, never the flag
      cmp_a_out_next = (timer_tick & hit_a_reg) | force_compare_a_strobe;
      cmp_b_out_next = (timer_tick & hit_b_reg) | force_compare_b_strobe;
   end

   // APB answer: no wait state, read data prepared in setup
   always_comb
   begin
      pready_next = psel & ~penable & ~pready_reg;
      pslverr_next = pslverr_reg;
      prdata_next = prdata_reg;
      if (psel && !penable)
      begin
         pslverr_next = ~addr_ok;
         prdata_next = 32'h00000000;
         if (!pwrite)
         begin
            case (paddr)
               `TEFL_OFS_FLAGS: prdata_next = {24'h000000, timer_interrupt_flags_reg};
               `TEFL_OFS_MASK: prdata_next = {24'h000000, timer_interrupt_mask_reg};
               `TEFL_OFS_CTRL: prdata_next = {26'h0, ctrl_reg};
               `TEFL_OFS_CAPT: prdata_next = {16'h0000, capture_reg};
               default: prdata_next = 32'h00000000;
            endcase
         end
      end
   end

   // All state registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         timer_interrupt_flags_reg <= `TEFL_FLAGS_RST;
         timer_interrupt_mask_reg <= `TEFL_MASK_RST;
         ctrl_reg <= `TEFL_CTRL_RST;
         capture_reg <= `TEFL_CAPT_RST;
         hit_a_reg <= 1'b0;
         hit_b_reg <= 1'b0;
         irq_reg <= 4'h0;
         cmp_a_out_reg <= 1'b0;
         cmp_b_out_reg <= 1'b0;
         prdata_reg <= 32'h00000000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end
      else
      begin
         timer_interrupt_flags_reg <= timer_interrupt_flags_next;
         timer_interrupt_mask_reg <= timer_interrupt_mask_next;
         ctrl_reg <= ctrl_next;
         capture_reg <= capture_next;
         hit_a_reg <= hit_a_next;
         hit_b_reg <= hit_b_next;
         irq_reg <= irq_next;
         cmp_a_out_reg <= cmp_a_out_next;
         cmp_b_out_reg <= cmp_b_out_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   // Outputs straight from flops
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign irq_request = irq_reg;
   assign compare_a_event = cmp_a_out_reg;
   assign compare_b_event = cmp_b_out_reg;
   assign capture_register = capture_reg;
   assign waveform_mode_field = mode;
endmodule

//--- verif/tefl_top_monitor.sv
// Purpose: Port assertions for tefl_top
// Assumes: One clock, async active-low reset
// Notes: Bound from the bench top
`timescale 1ns/10ps
module tefl_top_monitor
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic timer_tick,
   input wire tefl_pkg::tefl_word_t wide_counter_value,
   input wire tefl_pkg::tefl_word_t compare_register_a,
   input wire logic mode_overflow_event,
   input wire logic [3:0] vector_executed,
   input wire logic [3:0] irq_request,
   input wire logic compare_a_event,
   input wire tefl_pkg::tefl_word_t capture_register,
   input wire tefl_pkg::tefl_mode_t waveform_mode_field
);
   import tefl_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Bus answer timing
   chk_pready_slot: assert property (psel && !penable |=> pready ##1 !pready) else $error("pready slot");
   chk_pready_access: assert property (pready |-> psel && penable) else $error("pready outside access");
   chk_unmapped_err: assert property (pready && paddr > 12'h00C |-> pslverr && prdata == 32'h0) else $error("unmapped");
   // Match reported one tick late
   chk_cmp_late: assert property (timer_tick && wide_counter_value == compare_register_a ##1 timer_tick
      |=> compare_a_event) else $error("compare A late");
   chk_vector_clear: assert property (vector_executed[0] && !timer_tick && !mode_overflow_event
      |=> ##1 !irq_request[0]) else $error("vector clear");
   // Request needs a flag event or a mask or control write
   chk_irq_cause: assert property ($rose(irq_request[2]) |-> $past(compare_a_event) || $past(psel, 2))
      else $error("irq without cause");
   chk_capture_copy: assert property ($changed(capture_register) |-> capture_register == $past(wide_counter_value))
      else $error("capture value");
   chk_mode_write: assert property ($changed(waveform_mode_field) |-> $past(psel) || $past(psel, 2))
      else $error("mode without write");
   cover property (vector_executed[0]);
   cover property (compare_a_event);
   cover property (pready && pslverr);
endmodule

//--- verif/tefl_cpu_model.sv
// Purpose: CPU interrupt side of tefl_top
// Assumes: Vector runs the cycle after a request is seen, once the quiet period is over
// Notes: Quiet after each vector so the request can drop
`timescale 1ns/10ps
module tefl_cpu_model
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic enable,
   input wire logic [3:0] irq_request,
   output logic [3:0] vector_executed
);
   logic [1:0] hold_reg;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         vector_executed <= 4'h0;
         hold_reg <= 2'h0;
      end
      else
      begin
         vector_executed <= 4'h0;
         if (hold_reg != 2'h0)
            hold_reg <= hold_reg - 2'h1;
         else if (enable && |irq_request)
         begin
            vector_executed <= irq_request;
            hold_reg <= 2'h3;
         end
      end
   end
endmodule

//--- verif/tefl_top_bench.sv
// Purpose: Self-checking bench for tefl_top
// Assumes: Ticks one cycle apart, driven by the bench
// Notes: CPU side is tefl_cpu_model
`timescale 1ns/10ps
`include "tefl_map.svh"
module tefl_top_bench;
   import tefl_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tick, fa, fb, movf, pin, ca, cb, cpu_on;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [3:0] oset, vec, irq;
   tefl_word_t cnt, cmpa, cmpb, capt;
   tefl_mode_t mode;
   int n_mismatch, comparisons;
   tefl_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer_tick(tick), .wide_counter_value(cnt), .compare_register_a(cmpa), .compare_register_b(cmpb),
      .force_compare_a_strobe(fa), .force_compare_b_strobe(fb), .mode_overflow_event(movf),
      .capture_input_pin(pin), .other_timer_flag_set(oset), .vector_executed(vec), .irq_request(irq),
      .compare_a_event(ca), .compare_b_event(cb), .capture_register(capt), .waveform_mode_field(mode));
   tefl_cpu_model cpu (.pclk(pclk), .presetn(presetn), .enable(cpu_on), .irq_request(irq), .vector_executed(vec));
   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Request held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // No cycle limit here; only the watchdog ends a hung wait
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), e, q);
   endtask
   // Consecutive ticks, counting up from v
   task automatic ticks(input tefl_word_t v, input int n);
      tick <= 1'b1;
      repeat (n)
      begin
         cnt <= v;
         v++;
         @(posedge pclk);
      end
      tick <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic t_reset();
      rd(`TEFL_OFS_FLAGS, 32'h0);
      rd(`TEFL_OFS_MASK, 32'h0);
      rd(`TEFL_OFS_CTRL, 32'h0);
      rd(`TEFL_OFS_CAPT, 32'h0);
      rd(12'h010, 32'h0);
      chk("pslverr", 32'h1, {31'h0, pslverr});
      oset <= 4'hF;
      @(posedge pclk);
      oset <= 4'h0;
      @(posedge pclk);
      rd(`TEFL_OFS_FLAGS, 32'hC3);
      apb(1'b1, `TEFL_OFS_FLAGS, 32'hC3);
      rd(`TEFL_OFS_FLAGS, 32'h0);
   endtask
   task automatic t_compare();
      fa <= 1'b1; fb <= 1'b1;
      @(posedge pclk);
      fa <= 1'b0; fb <= 1'b0;
      @(posedge pclk);
      chk("forced compare events", 32'h3, {30'h0, ca, cb});
      rd(`TEFL_OFS_FLAGS, 32'h0);
      ticks(16'h0010, 1);
      rd(`TEFL_OFS_FLAGS, 32'h0);
      ticks(16'h0011, 1);
      rd(`TEFL_OFS_FLAGS, 32'h10);
      ticks(16'h0020, 2);
      chk("compare_b_event", 32'h1, {31'h0, cb});
      rd(`TEFL_OFS_FLAGS, 32'h18);
      apb(1'b1, `TEFL_OFS_FLAGS, 32'h0);
      rd(`TEFL_OFS_FLAGS, 32'h18);
      apb(1'b1, `TEFL_OFS_FLAGS, 32'h10);
      rd(`TEFL_OFS_FLAGS, 32'h08);
      apb(1'b1, `TEFL_OFS_FLAGS, 32'h08);
   endtask
   task automatic t_overflow();
      foreach (cnt[i])
         if (i == 0 || i == 4)
         begin
            apb(1'b1, `TEFL_OFS_CTRL, i);
            ticks(16'hFFFF, 1);
            rd(`TEFL_OFS_FLAGS, 32'h04);
            apb(1'b1, `TEFL_OFS_FLAGS, 32'h04);
         end
      apb(1'b1, `TEFL_OFS_CTRL, 32'h0E);
      ticks(16'hFFFF, 1);
      rd(`TEFL_OFS_FLAGS, 32'h0);
      movf <= 1'b1;
      @(posedge pclk);
      movf <= 1'b0;
      rd(`TEFL_OFS_FLAGS, 32'h04);
      apb(1'b1, `TEFL_OFS_FLAGS, 32'h04);
   endtask
   task automatic t_capture();
      apb(1'b1, `TEFL_OFS_CTRL, 32'h10);
      cnt <= 16'h1234;
      pin <= 1'b1;
      repeat (6) @(posedge pclk);
      rd(`TEFL_OFS_FLAGS, 32'h20);
      rd(`TEFL_OFS_CAPT, 32'h1234);
      chk("capture_register", 32'h1234, {16'h0, capt});
      apb(1'b1, `TEFL_OFS_FLAGS, 32'h20);
      pin <= 1'b0;
      repeat (6) @(posedge pclk);
      rd(`TEFL_OFS_FLAGS, 32'h0);
      apb(1'b1, `TEFL_OFS_CTRL, 32'h1C);
      chk("waveform_mode_field", 32'hC, {28'h0, mode});
      pin <= 1'b1;
      repeat (6) @(posedge pclk);
      rd(`TEFL_OFS_FLAGS, 32'h0);
      // Pin falls while ignored; the tick at 16'h1234 then sets the capture flag from the ceiling match
      pin <= 1'b0;
      ticks(16'h1234, 1);
      rd(`TEFL_OFS_FLAGS, 32'h20);
      apb(1'b1, `TEFL_OFS_FLAGS, 32'h20);
   endtask
   task automatic t_irq();
      apb(1'b1, `TEFL_OFS_CTRL, 32'h0);
      apb(1'b1, `TEFL_OFS_MASK, 32'h14);
      ticks(16'hFFFF, 1);
      repeat (3) @(posedge pclk);
      chk("irq", 32'h0, irq);
      apb(1'b1, `TEFL_OFS_CTRL, 32'h20);
      // Request trails the global enable by one cycle
      @(posedge pclk);
      chk("irq", 32'h1, irq);
      cpu_on <= 1'b1;
      repeat (8) @(posedge pclk);
      cpu_on <= 1'b0;
      chk("irq", 32'h0, irq);
      rd(`TEFL_OFS_FLAGS, 32'h0);
      // Back-to-back ticks: compare A match raises its request
      ticks(16'h0010, 2);
      @(posedge pclk);
      chk("irq", 32'h4, irq);
      apb(1'b1, `TEFL_OFS_FLAGS, 32'h10);
      @(posedge pclk);
      chk("irq", 32'h0, irq);
   endtask
   task automatic conclude();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Hang guard, well past the scenario length
   initial
   begin
      repeat (5000) @(posedge pclk);
      n_mismatch++;
      conclude();
   end
   initial
   begin
      {psel, penable, pwrite, tick, fa, fb, movf, pin, cpu_on} = '0;
      paddr = '0; pwdata = '0; oset = '0; cnt = '0; cmpa = 16'h0010; cmpb = 16'h0020;
      n_mismatch = 0; comparisons = 0; presetn = 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_compare();
      t_overflow();
      t_capture();
      t_irq();
      conclude();
   end
endmodule
bind tefl_top tefl_top_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_tick(timer_tick),
   .wide_counter_value(wide_counter_value), .compare_register_a(compare_register_a),
   .mode_overflow_event(mode_overflow_event), .vector_executed(vector_executed), .irq_request(irq_request),
   .compare_a_event(compare_a_event), .capture_register(capture_register), .waveform_mode_field(waveform_mode_field));
